/* File: core/split_stamp_counter.sv */
// Split timestamp counter with reference-edge synchronised clear and APB registers
module split_stamp_counter #(
  parameter int unsigned MS_TICK_CYCLES = stamp_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [stamp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Reference pins and card events
  input  wire logic                         ref_clock,
  input  wire logic                         ref_fitted,
  input  wire logic                         card_start,
  // Timestamp outputs
  output logic      [31:0]                  stamp_high,
  output logic      [31:0]                  stamp_low,
  output logic                              stamp_enable,
  output logic                              irq
);
  import stamp_pkg::*;

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0]    command;
    logic [31:0]    start_time;
    logic [31:0]    start_date;
    logic [31:0]    host_time;
    logic [31:0]    host_date;
    logic [31:0]    edge_wait;
    logic [31:0]    count_high;
    logic [31:0]    count_low;
    logic [EVT_W-1:0] irq_status;
    logic [EVT_W-1:0] irq_enable;
    sync_state_t    sync_state;
    logic [31:0]    ms_pre;
    logic [31:0]    ms_elapsed;
    logic           ref_meta;
    logic           ref_sync;
    logic           ref_last;
    logic           fit_meta;
    logic           fit_sync;
    logic [31:0]    rdata;
  } state_t;

  state_t cur;
  state_t nxt;

  logic [15:0]      word_idx;
  logic             wr_access;
  logic             rd_setup;
  logic             mapped;
  logic [7:0]       mode;
  logic [3:0]       source;
  logic             split;
  logic             ref_edge;
  logic             clear_now;
  logic [EVT_W-1:0] events;
  logic [EVT_W-1:0] clear_mask;
  logic [63:0]      full_count;

  assign word_idx = paddr[ADDR_W-1:2];
  assign wr_access = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mode = cur.command[MODE_LSB +: 8];
  assign source = cur.command[SOURCE_LSB +: 4];

  always_comb begin
    unique case (word_idx)
      IDX_STAMP_COMMAND, IDX_START_TIME, IDX_START_DATE, IDX_HOST_TIME,
      IDX_HOST_DATE, IDX_EDGE_WAIT, IDX_COUNT_LOW, IDX_COUNT_HIGH,
      IDX_IRQ_STATUS, IDX_IRQ_ENABLE, IDX_IRQ_CLEAR, IDX_SYNC_STATE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  //----------------------------------------------------------------------------
  // Counting and synchronised clear
  //----------------------------------------------------------------------------
  always_comb begin
    nxt = cur;
    events = '0;
    clear_mask = '0;
    clear_now = 1'b0;
    // Two flops before any logic sees the pins
    nxt.ref_meta = ref_clock;
    nxt.ref_sync = cur.ref_meta;
    nxt.ref_last = cur.ref_sync;
    nxt.fit_meta = ref_fitted;
    nxt.fit_sync = cur.fit_meta;
    full_count = {cur.count_high, cur.count_low} + 64'h1;

    // split only with a fitted reference
    split = cur.fit_sync &&
            (source == SPLIT_RISING_EDGE || source == SPLIT_FALLING_EDGE);
    ref_edge = (source == SPLIT_RISING_EDGE) ? (cur.ref_sync & ~cur.ref_last)
                                             : (~cur.ref_sync & cur.ref_last);

    if (mode != STAMPING_OFF_CODE) begin
      if (split) begin
        if (ref_edge) begin
          nxt.count_high = cur.count_high + 32'h1;
          nxt.count_low = 32'h0;
        end else begin
          nxt.count_low = cur.count_low + 32'h1;
        end
      end else begin
        nxt.count_high = full_count[63:32];
        nxt.count_low = full_count[31:0];
      end
    end

    if (card_start && mode == CLEAR_ON_START) begin
      clear_now = 1'b1;
    end

    // Millisecond prescaler only runs while waiting, so each wait starts aligned
    unique case (cur.sync_state)
      SYNC_IDLE: begin
        nxt.ms_pre = 32'h0;
        nxt.ms_elapsed = 32'h0;
      end
      SYNC_WAIT: begin
        if (split && ref_edge) begin
          nxt.start_time = cur.host_time;
          nxt.start_date = cur.host_date;
          clear_now = 1'b1;
          events[EVT_SYNC_DONE] = 1'b1;
          nxt.sync_state = SYNC_IDLE;
        end else if (cur.ms_elapsed >= cur.edge_wait) begin
          events[EVT_SYNC_TIMEOUT] = 1'b1;
          nxt.sync_state = SYNC_IDLE;
        end else if (cur.ms_pre == MS_TICK_CYCLES - 1) begin
          nxt.ms_pre = 32'h0;
          nxt.ms_elapsed = cur.ms_elapsed + 32'h1;
        end else begin
          nxt.ms_pre = cur.ms_pre + 32'h1;
        end
      end
    endcase

    //--------------------------------------------------------------------------
    // APB writes
    //--------------------------------------------------------------------------
    if (wr_access) begin
      unique case (word_idx)
        IDX_STAMP_COMMAND: begin
          // command holds ORed codes; clear bit is not stored
          nxt.command = pwdata & ~(32'h1 << CLEAR_BIT);
          if (pwdata[CLEAR_BIT]) begin
            // reference mode waits for an edge
            if (cur.fit_sync && (pwdata[SOURCE_LSB +: 4] == SPLIT_RISING_EDGE ||
                                 pwdata[SOURCE_LSB +: 4] == SPLIT_FALLING_EDGE)) begin
              nxt.sync_state = SYNC_WAIT;
              nxt.ms_pre = 32'h0;
              nxt.ms_elapsed = 32'h0;
            end else begin
              clear_now = 1'b1;
            end
          end
        end
        // time word layout kept as written
        IDX_START_TIME: nxt.start_time = pwdata;
        // date word layout kept as written
        IDX_START_DATE: nxt.start_date = pwdata;
        IDX_HOST_TIME:  nxt.host_time = pwdata;
        IDX_HOST_DATE:  nxt.host_date = pwdata;
        IDX_EDGE_WAIT:  nxt.edge_wait = pwdata;
        IDX_IRQ_ENABLE: nxt.irq_enable = pwdata[EVT_W-1:0];
        IDX_IRQ_CLEAR:  clear_mask = pwdata[EVT_W-1:0];
        default: ;
      endcase
    end

    if (clear_now) begin
      nxt.count_high = 32'h0;
      nxt.count_low = 32'h0;
    end

    // New events win over a clear in the same cycle
    nxt.irq_status = (cur.irq_status & ~clear_mask) | events;

    //--------------------------------------------------------------------------
    // APB read data, captured in the setup phase
    //--------------------------------------------------------------------------
    if (rd_setup) begin
      unique case (word_idx)
        IDX_STAMP_COMMAND: nxt.rdata = cur.command;
        IDX_START_TIME:    nxt.rdata = cur.start_time;
        IDX_START_DATE:    nxt.rdata = cur.start_date;
        IDX_HOST_TIME:     nxt.rdata = cur.host_time;
        IDX_HOST_DATE:     nxt.rdata = cur.host_date;
        IDX_EDGE_WAIT:     nxt.rdata = cur.edge_wait;
        IDX_COUNT_LOW:     nxt.rdata = cur.count_low;
        IDX_COUNT_HIGH:    nxt.rdata = cur.count_high;
        IDX_IRQ_STATUS:    nxt.rdata = {{(32-EVT_W){1'b0}}, cur.irq_status};
        IDX_IRQ_ENABLE:    nxt.rdata = {{(32-EVT_W){1'b0}}, cur.irq_enable};
        IDX_SYNC_STATE:    nxt.rdata = {31'h0, cur.sync_state == SYNC_WAIT};
        default:           nxt.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
      cur.command <= COMMAND_RESET;
      cur.edge_wait <= EDGE_WAIT_RESET;
      cur.sync_state <= SYNC_IDLE;
    end else begin
      cur <= nxt;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  assign prdata = cur.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign stamp_high = cur.count_high;
  assign stamp_low = cur.count_low;
  assign stamp_enable = (mode != STAMPING_OFF_CODE);
  assign irq = |(cur.irq_status & cur.irq_enable);

endmodule : split_stamp_counter

/* File: shared/stamp_pkg.sv */
// Package with register map, command codes and timing constants for the split timestamp counter
//------------------------------------------------------------------------------
// Function
// - Reference mode splits counter into two parts
// - Reference edge clears low, increments high
// - Low counts sample cycles, high counts edges
// - Reset command zeroes both counter parts
// - Reset code clears; reference mode waits edge
// - Timeout in milliseconds readable and writable
// - Rising-edge code counts reference rising edges
// - Falling-edge code counts reference falling edges
// - Time word: hours, minutes, seconds fields
// - Date word: year, month, day fields
// - Mode 2h clears only on command
// - Mode 4h clears on every card start
// - Edge found latches host time and date
// - Missing reference input leaves counting unaffected
// - Source 100h counts full width internally
//------------------------------------------------------------------------------
package stamp_pkg;

  //----------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  //----------------------------------------------------------------------------
  localparam logic [15:0] IDX_STAMP_COMMAND  = 16'hB798;
  localparam logic [15:0] IDX_START_TIME     = 16'hB7B6;
  localparam logic [15:0] IDX_START_DATE     = 16'hB7B7;
  localparam logic [15:0] IDX_HOST_TIME      = 16'hB7B8;
  localparam logic [15:0] IDX_HOST_DATE      = 16'hB7B9;
  localparam logic [15:0] IDX_EDGE_WAIT      = 16'hB7C5;
  localparam logic [15:0] IDX_COUNT_LOW      = 16'hB7C6;
  localparam logic [15:0] IDX_COUNT_HIGH     = 16'hB7C7;
  localparam logic [15:0] IDX_IRQ_STATUS     = 16'hB7C8;
  localparam logic [15:0] IDX_IRQ_ENABLE     = 16'hB7C9;
  localparam logic [15:0] IDX_IRQ_CLEAR      = 16'hB7CA;
  localparam logic [15:0] IDX_SYNC_STATE     = 16'hB7CB;

  localparam int          ADDR_W             = 18;

  //----------------------------------------------------------------------------
  // Command codes and fields
  //----------------------------------------------------------------------------
  localparam int          CLEAR_BIT          = 0;
  localparam logic [7:0]  STAMPING_OFF_CODE  = 8'h00;
  localparam logic [7:0]  EXPLICIT_CLEAR     = 8'h02;
  localparam logic [7:0]  CLEAR_ON_START     = 8'h04;
  localparam logic [3:0]  FULL_WIDTH_COUNT   = 4'h1;
  localparam logic [3:0]  SPLIT_RISING_EDGE  = 4'h2;
  localparam logic [3:0]  SPLIT_FALLING_EDGE = 4'h4;
  localparam int          MODE_LSB           = 0;
  localparam int          SOURCE_LSB         = 8;

  //----------------------------------------------------------------------------
  // Reset values and status bits
  //----------------------------------------------------------------------------
  localparam logic [31:0] COMMAND_RESET      = 32'h0000_0000;
  localparam logic [31:0] EDGE_WAIT_RESET    = 32'h0000_03E8;
  localparam int          EVT_SYNC_DONE      = 0;
  localparam int          EVT_SYNC_TIMEOUT   = 1;
  localparam int          EVT_W              = 2;

  //----------------------------------------------------------------------------
  // Timing
  //----------------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS      = 40;
  localparam int          MILLISECOND_NS     = 1000000;
  localparam int          MS_CYCLES          = MILLISECOND_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SYNC_IDLE = 2'b01,
    SYNC_WAIT = 2'b10
  } sync_state_t;

endpackage : stamp_pkg

/* File: tb/ref_source.sv */
// Reference clock source standing at the far side of the reference pin
module ref_source #(
  parameter int HALF = 20
) (
  // Clock and control
  input  wire logic pclk,
  input  wire logic run,
  // Reference pin
  output logic      ref_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial ref_clock = 1'b0;
  // Stands still when stopped, so no stray edge reaches a wait
  always @(posedge pclk) begin
    if (!run)
      cnt <= 0;
    else if (cnt == HALF - 1) begin
      cnt <= 0;
      ref_clock <= ~ref_clock;
    end else
      cnt <= cnt + 1;
  end
endmodule : ref_source

/* File: tb/split_stamp_counter_chk.sv */
// Port checker for the split timestamp counter
module split_stamp_counter_chk (
  // Clock, reset and bus
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [stamp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic                         pready,
  // Reference and counter
  input wire logic                         ref_clock,
  input wire logic                         ref_fitted,
  input wire logic                         card_start,
  input wire logic [31:0]                  stamp_high,
  input wire logic [31:0]                  stamp_low,
  input wire logic                         stamp_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  import stamp_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] cmd_q;
  wire logic        wr = psel && penable && pwrite;
  wire logic        cw = wr && paddr[ADDR_W-1:2] == IDX_STAMP_COMMAND;
  wire logic [63:0] cnt = {stamp_high, stamp_low};
  wire logic        quiet = stamp_enable && !wr && !card_start;
  // Shadow of the command word; the clear bit is a strobe and is not kept
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cmd_q <= COMMAND_RESET;
    else if (cw)
      cmd_q <= pwdata & ~(32'h1 << CLEAR_BIT);
  chk_pready_set: assert property (psel |-> pready) else $error("pready low");
  chk_off_hold: assert property (
    !stamp_enable && !wr |=> $stable(cnt)) else $error("count moved while off");
  chk_count_step: assert property (
    quiet |=> cnt == $past(cnt) + 64'h1 || stamp_low == 32'h0) else $error("bad step");
  chk_full_width: assert property (
    quiet && cmd_q[11:8] == FULL_WIDTH_COUNT |=> cnt == $past(cnt) + 64'h1)
    else $error("full count wrong");
  chk_unfitted_count: assert property (
    quiet && !ref_fitted && !$past(ref_fitted) && !$past(ref_fitted, 2)
    |=> cnt == $past(cnt) + 64'h1)
    else $error("unfitted count wrong");
  chk_clear_zero: assert property (
    cw && pwdata[CLEAR_BIT] && pwdata[11:8] == FULL_WIDTH_COUNT |=> cnt == 64'h0)
    else $error("clear missed");
  chk_start_clear: assert property (
    card_start && !wr && cmd_q[7:0] == CLEAR_ON_START |-> ##[1:2] cnt == 64'h0)
    else $error("start clear missed");
  chk_rise_split: assert property (
    stamp_enable && ref_fitted && cmd_q[11:8] == SPLIT_RISING_EDGE && $rose(ref_clock)
    |-> ##[2:4] stamp_low == 32'h0) else $error("rising edge missed");
  chk_fall_split: assert property (
    stamp_enable && ref_fitted && cmd_q[11:8] == SPLIT_FALLING_EDGE && $fell(ref_clock)
    |-> ##[2:4] stamp_low == 32'h0) else $error("falling edge missed");
  cover property (cw && pwdata[CLEAR_BIT]);
  cover property (card_start && cmd_q[7:0] == CLEAR_ON_START);
  cover property (stamp_enable && ref_fitted && $rose(ref_clock));
endmodule : split_stamp_counter_chk

bind split_stamp_counter split_stamp_counter_chk i_split_stamp_counter_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .ref_clock(ref_clock),
  .ref_fitted(ref_fitted), .card_start(card_start), .stamp_high(stamp_high),
  .stamp_low(stamp_low), .stamp_enable(stamp_enable));

/* File: tb/split_stamp_counter_tb.sv */
// Self-checking bench for the split timestamp counter
module split_stamp_counter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import stamp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic ref_fitted = 0, card_start = 0, run = 0, ref_clock, pready, pslverr, irq, stamp_enable;
  logic [ADDR_W-1:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, stamp_high, stamp_low, rd, v, tm;
  logic        err;
  logic [3:0]  srcs [3] = '{FULL_WIDTH_COUNT, SPLIT_RISING_EDGE, SPLIT_FALLING_EDGE};
  logic [7:0]  modes [2] = '{EXPLICIT_CLEAR, CLEAR_ON_START};
  int seed = 96, error_cnt = 0, checked = 0, cycles = 0;
  always #20 pclk = ~pclk;
  split_stamp_counter #(.MS_TICK_CYCLES(4)) i_split_stamp_counter (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_clock(ref_clock), .ref_fitted(ref_fitted), .card_start(card_start),
    .stamp_high(stamp_high), .stamp_low(stamp_low), .stamp_enable(stamp_enable), .irq(irq));
  ref_source #(.HALF(20)) i_ref_source (.pclk(pclk), .run(run), .ref_clock(ref_clock));
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic apb(logic w, logic [15:0] idx, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] cmd(logic [7:0] m, logic [3:0] s, logic c);
    return {20'h0, s, m} | {31'h0, c};
  endfunction : cmd
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // Hang guard, well above the several hundred cycles the tests need
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, IDX_STAMP_COMMAND, 32'h0);
    chk("command", rd, COMMAND_RESET);
    apb(0, IDX_EDGE_WAIT, 32'h0);
    chk("edge_wait", rd, EDGE_WAIT_RESET);
    v = $random(seed);
    apb(1, IDX_EDGE_WAIT, v);
    apb(0, IDX_EDGE_WAIT, 32'h0);
    chk("edge_wait rw", rd, v);
    apb(0, 16'h0010, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    $display("registers done");
    foreach (srcs[i]) begin
      apb(1, IDX_STAMP_COMMAND, cmd(EXPLICIT_CLEAR, srcs[i], 1'b1));
      repeat (10) @(posedge pclk);
      #1;
      chk("count_low", stamp_low, 32'hA);
      chk("count_high", stamp_high, 32'h0);
    end
    apb(1, IDX_STAMP_COMMAND, {24'h0, STAMPING_OFF_CODE});
    #1;
    v = stamp_low;
    repeat (5) @(posedge pclk);
    #1;
    chk("held", {stamp_low[30:0], stamp_enable}, {v[30:0], 1'b0});
    $display("plain count done");
    foreach (modes[i]) begin
      apb(1, IDX_STAMP_COMMAND, cmd(modes[i], FULL_WIDTH_COUNT, 1'b0));
      repeat (8 + $unsigned($random(seed)) % 16) @(posedge pclk);
      card_start <= 1'b1;
      @(posedge pclk);
      card_start <= 1'b0;
      repeat (2) @(posedge pclk);
      #1;
      chk("start", {31'h0, stamp_low < 32'h4}, {31'h0, modes[i] == CLEAR_ON_START});
    end
    $display("card start done");
    ref_fitted <= 1'b1;
    apb(1, IDX_EDGE_WAIT, EDGE_WAIT_RESET);
    apb(1, IDX_IRQ_ENABLE, 32'h1);
    for (int i = 1; i < 3; i++) begin
      tm = $random(seed);
      v = $random(seed);
      apb(1, IDX_HOST_TIME, tm);
      apb(1, IDX_HOST_DATE, v);
      apb(1, IDX_STAMP_COMMAND, cmd(EXPLICIT_CLEAR, srcs[i], 1'b1));
      run <= 1'b1;
      for (int n = 0; n < 300 && irq !== 1'b1; n++) @(posedge pclk);
      chk("sync irq", {31'h0, irq}, 32'h1);
      repeat (90) @(posedge pclk);
      chk("count_high", stamp_high, 32'h2);
      apb(0, IDX_START_TIME, 32'h0);
      chk("start time", rd, tm);
      apb(0, IDX_START_DATE, 32'h0);
      chk("start date", rd, v);
      run <= 1'b0;
      apb(1, IDX_IRQ_CLEAR, 32'h3);
      repeat (5) @(posedge pclk);
      chk("irq cleared", {31'h0, irq}, 32'h0);
    end
    $display("sync done");
    apb(1, IDX_HOST_TIME, ~tm);
    apb(1, IDX_EDGE_WAIT, 32'h2);
    apb(1, IDX_STAMP_COMMAND, cmd(EXPLICIT_CLEAR, SPLIT_RISING_EDGE, 1'b1));
    // Two ticks of four cycles each, with margin
    repeat (40) @(posedge pclk);
    apb(0, IDX_IRQ_STATUS, 32'h0);
    chk("status", {rd[31:1], irq}, 32'h2);
    apb(0, IDX_START_TIME, 32'h0);
    chk("start kept", rd, tm);
    apb(1, IDX_IRQ_ENABLE, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, irq}, 32'h1);
    $display("timeout done");
    summarize();
  end
endmodule : split_stamp_counter_tb
